// File: tmint_pkg.sv
// Contract
// - periodic register: ptimer flags bits 7..4, enables bits 3..0, reset zero
// - small variant: stimer0 flags bits 5,4, enables 1,0, others read zero
// - large variant: stimer flags bits 7..4, enables bits 3..0, reset zero
// - an event sets its flag regardless of any enable bit
// - a set flag vectors only when its own enable is one
// - global enable at zero suppresses every interrupt
// - taking an interrupt pushes next pc and loads the vector
// - return from interrupt pops the saved pc
// - taking an interrupt clears the global enable
// - requests during servicing still set and keep their flags
// - no acknowledge while the stack is full
// - any set flag wakes the device from sleep or idle
package tmint_pkg;
  localparam int          ADDR_W         = 4;
  localparam int          PC_W           = 16;
  localparam int          NSRC           = 8;
  localparam int          STACK_DEPTH    = 16;
  localparam int          SP_W           = 5;
  localparam logic [3:0]  OFS_PTIMER     = 4'h0;
  localparam logic [3:0]  OFS_STIMER     = 4'h1;
  localparam logic [3:0]  OFS_GLOBAL     = 4'h2;
  localparam logic [3:0]  OFS_STATUS     = 4'h3;
  localparam logic [3:0]  OFS_VECTOR_LO  = 4'h4;
  localparam int          FLAG_LSB       = 4;
  localparam int          EN_LSB         = 0;
  localparam int          GIE_BIT        = 0;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  SMALL_MASK     = 8'h33;
  localparam logic [7:0]  LARGE_MASK     = 8'hFF;
  localparam logic [15:0] VECTOR_BASE    = 16'h0010;
  localparam logic [15:0] VECTOR_STEP    = 16'h0004;
endpackage

// File: tmint_prio.sv
module tmint_prio
  import tmint_pkg::*;
(
  input  wire logic [NSRC-1:0] req,
  output logic                 any,
  output logic [2:0]           idx
);
  always_comb
  begin
    any = 1'b0;
    idx = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
  end
endmodule

// File: tmint_ctrl.sv
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
module tmint_ctrl
  import tmint_pkg::*;
#(
  parameter bit LARGE = 1'b1
)
(
  input  wire logic                CLOCK,
  input  wire logic                NRST,
  input  wire logic [ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [31:0]         AVS_WRITEDATA,
  output logic [31:0]              AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  input  wire logic [NSRC-1:0]     MATCH_EVENT,
  input  wire logic [PC_W-1:0]     NEXT_PC,
  input  wire logic                INSTR_BOUNDARY,
  input  wire logic                RETURN_FROM_INTERRUPT,
  input  wire logic                LOW_POWER,
  output logic                     PC_LOAD,
  output logic [PC_W-1:0]          PC_VALUE,
  output logic                     IRQ,
  output logic                     WAKE
);
  import tmint_pkg::*;

  typedef struct packed {
    logic [7:0]             ptimer;
    logic [7:0]             stimer;
    logic                   gie;
    logic [SP_W-1:0]        sp;
    logic                   pc_load;
    logic [PC_W-1:0]        pc_value;
    logic                   ack;
    logic [31:0]            rdata;
    logic                   wake;
  } state_t;

  state_t                   cur_ff;
  state_t                   nxt_ff;
  logic [PC_W-1:0]          stack_mem_ff [STACK_DEPTH];
  logic [NSRC-1:0]          flags;
  logic [NSRC-1:0]          enables;
  logic [NSRC-1:0]          pending;
  logic                     any_req;
  logic [2:0]               win_idx;
  logic                     stack_full;
  logic                     take;
  logic                     pop;
  logic [7:0]               stimer_mask;
  logic                     bus_req;

  // source order: ptimer0 P, ptimer0 A, ptimer1 P, ptimer1 A, then stimer same
  assign stimer_mask = LARGE ? LARGE_MASK : SMALL_MASK;
  assign flags   = {cur_ff.stimer[7:4], cur_ff.ptimer[7:4]};
  assign enables = {cur_ff.stimer[3:0], cur_ff.ptimer[3:0]};
  assign pending = flags & enables;
  assign stack_full = (cur_ff.sp == SP_W'(STACK_DEPTH));
  assign bus_req = AVS_READ | AVS_WRITE;

  tmint_prio u_prio
  (
    .req (pending),
    .any (any_req),
    .idx (win_idx)
  );

  assign take = any_req & cur_ff.gie & ~stack_full & INSTR_BOUNDARY & ~RETURN_FROM_INTERRUPT;
  assign pop  = RETURN_FROM_INTERRUPT & (cur_ff.sp != '0);

  always_comb
  begin
    logic [7:0] set_p;
    logic [7:0] set_s;
    logic [7:0] wd;
    set_p = {MATCH_EVENT[3:0], 4'h0};
    set_s = {MATCH_EVENT[7:4], 4'h0} & stimer_mask;
    wd    = AVS_WRITEDATA[7:0];
    nxt_ff = cur_ff;
    nxt_ff.pc_load = 1'b0;
    nxt_ff.ack = 1'b0;
    // a write lands at the edge where the master sees waitrequest low
    if (AVS_WRITE && cur_ff.ack)
    begin
      unique case (AVS_ADDRESS)
        OFS_PTIMER: nxt_ff.ptimer = wd;
        OFS_STIMER: nxt_ff.stimer = wd & stimer_mask;
        OFS_GLOBAL: nxt_ff.gie = wd[GIE_BIT];
        default: ;
      endcase
    end
    if (bus_req && !cur_ff.ack)
    begin
      nxt_ff.ack = 1'b1;
      nxt_ff.rdata = 32'h0000_0000;
      if (!AVS_WRITE)
      begin
        unique case (AVS_ADDRESS)
          OFS_PTIMER:    nxt_ff.rdata = {24'h0, cur_ff.ptimer};
          OFS_STIMER:    nxt_ff.rdata = {24'h0, cur_ff.stimer & stimer_mask};
          OFS_GLOBAL:    nxt_ff.rdata = {31'h0, cur_ff.gie};
          OFS_STATUS:    nxt_ff.rdata = {11'h0, stack_full, 7'h0, cur_ff.sp, pending};
          OFS_VECTOR_LO: nxt_ff.rdata = {16'h0, cur_ff.pc_value};
          default:       nxt_ff.rdata = 32'h0000_0000;
        endcase
      end
    end
    // set wins over a same-cycle software clear
    nxt_ff.ptimer = nxt_ff.ptimer | set_p;
    nxt_ff.stimer = nxt_ff.stimer | set_s;
    if (take)
    begin
      nxt_ff.gie = 1'b0;
      nxt_ff.sp = cur_ff.sp + SP_W'(1);
      nxt_ff.pc_load = 1'b1;
      nxt_ff.pc_value = VECTOR_BASE + PC_W'(VECTOR_STEP * PC_W'(win_idx));
    end
    else if (pop)
    begin
      nxt_ff.sp = cur_ff.sp - SP_W'(1);
      nxt_ff.pc_load = 1'b1;
      nxt_ff.pc_value = stack_mem_ff[cur_ff.sp[3:0] - 4'h1];
    end
    nxt_ff.wake = LOW_POWER & (|{nxt_ff.ptimer[7:4], nxt_ff.stimer[7:4]});
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // stack contents need no reset: only entries below the pointer are read
  always_ff @(posedge CLOCK)
  begin
    if (take)
    begin
      stack_mem_ff[cur_ff.sp[3:0]] <= NEXT_PC;
    end
  end

  assign AVS_WAITREQUEST = bus_req & ~cur_ff.ack;
  assign AVS_READDATA    = cur_ff.rdata;
  assign PC_LOAD         = cur_ff.pc_load;
  assign PC_VALUE        = cur_ff.pc_value;
  assign IRQ             = any_req & cur_ff.gie;
  assign WAKE            = cur_ff.wake;
endmodule

// File: tmint_props.sv
module tmint_props (
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [7:0]  MATCH_EVENT,
  input wire logic        INSTR_BOUNDARY,
  input wire logic        RETURN_FROM_INTERRUPT,
  input wire logic        LOW_POWER,
  input wire logic        PC_LOAD,
  input wire logic [15:0] PC_VALUE,
  input wire logic        IRQ,
  input wire logic        WAKE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // a load that does not follow a return is a vectoring
  sequence take;
    PC_LOAD && !$past(RETURN_FROM_INTERRUPT);
  endsequence
  sequence ask;
    $rose(AVS_READ || AVS_WRITE);
  endsequence
  chk_no_nest: assert property (take |-> !IRQ) else $error("irq after take");
  chk_one_take: assert property (take |=> !PC_LOAD [*2]) else $error("second take");
  chk_take_cause: assert property (take |-> $past(IRQ && INSTR_BOUNDARY))
    else $error("take without request");
  chk_vector_ok: assert property (take |-> PC_VALUE inside {16'h0010, 16'h0014, 16'h0018,
    16'h001C, 16'h0020, 16'h0024, 16'h0028, 16'h002C}) else $error("bad vector");
  chk_return_from_interrupt_pop: assert property (RETURN_FROM_INTERRUPT |=> PC_LOAD) else $error("no pop");
  chk_irq_cause: assert property ($rose(IRQ) |->
    $past(|MATCH_EVENT || AVS_WRITE || RETURN_FROM_INTERRUPT)) else $error("irq uncaused");
  chk_flag_wake: assert property (LOW_POWER && |MATCH_EVENT |-> ##[1:2] WAKE)
    else $error("no wake");
  chk_bus_answer: assert property (ask |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus answer late");
endmodule

// File: tmint_core_model.sv
module tmint_core_model (
  input  wire logic        CLOCK,
  input  wire logic        PC_LOAD,
  input  wire logic [15:0] PC_VALUE,
  output logic      [15:0] NEXT_PC,
  output logic             INSTR_BOUNDARY
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    NEXT_PC = 16'h0200;
    INSTR_BOUNDARY = 1'h0;
  end
  // multi-cycle instructions: a boundary is offered only now and then
  always @(posedge CLOCK)
  begin
    NEXT_PC <= PC_LOAD ? PC_VALUE + 16'h0001 : NEXT_PC + 16'h0001;
    INSTR_BOUNDARY <= 1'($urandom_range(1, 0));
  end
endmodule

// File: test_timer_match_interrupt_control.sv
module test_timer_match_interrupt_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLOCK = 1'h0, NRST = 1'h0, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
  logic        RETURN_FROM_INTERRUPT = 1'h0, LOW_POWER = 1'h0;
  logic        AVS_WAITREQUEST, INSTR_BOUNDARY, PC_LOAD, IRQ, WAKE;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic [7:0]  MATCH_EVENT = 8'h00;
  logic [15:0] NEXT_PC, PC_VALUE, np_q, ret;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, exp[$];
  int          bad_count = 0, compares = 0;
  always #5 CLOCK = ~CLOCK;
  tmint_ctrl dut (.*);
  tmint_core_model core (.*);
  task check(string n, logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task acc(logic w, logic [3:0] a, logic [7:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h0, d};
    do @(posedge CLOCK); while (AVS_WAITREQUEST);
    AVS_READ <= 1'h0;
    AVS_WRITE <= 1'h0;
    @(posedge CLOCK);
  endtask
  task rd(logic [3:0] a, logic [31:0] e);
    exp.push_back(e);
    acc(1'h0, a, 8'h00);
  endtask
  // the vectoring may land right after the enabling write, so expect first
  task take(logic [15:0] v);
    exp.push_back({16'h0, v});
    do @(posedge CLOCK); while (!PC_LOAD);
    ret = np_q;
    @(posedge CLOCK);
  endtask
  task return_from_interrupt;
    exp.push_back({16'h0, ret});
    RETURN_FROM_INTERRUPT <= 1'h1;
    @(posedge CLOCK);
    RETURN_FROM_INTERRUPT <= 1'h0;
    @(posedge CLOCK);
  endtask
  task conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0 && exp.size() == 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge CLOCK)
  begin
    np_q <= NEXT_PC;
    if (PC_LOAD)
      check("pc_value", {16'h0, PC_VALUE}, exp.pop_front());
    if (AVS_READ && !AVS_WAITREQUEST)
      check("readdata", AVS_READDATA, exp.pop_front());
  end
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    bad_count++;
    conclude;
  end
  initial
  begin
    void'($urandom(9));
    repeat (2) @(posedge CLOCK);
    NRST <= 1'h1;
    @(posedge CLOCK);
    for (int a = 0; a < 6; a++)
      rd(4'(a), 8'h00);
    acc(1'h1, 4'h1, 8'hFF);
    rd(4'h1, 8'hFF);
    acc(1'h1, 4'h2, 8'h01);
    take(16'h0020);
    rd(4'h2, 8'h00);
    acc(1'h1, 4'h1, 8'h00);
    return_from_interrupt;
    $display("test priority done");
    for (int i = 0; i < 8; i++)
    begin
      acc(1'h1, 4'h2, 8'h01);
      LOW_POWER <= 1'h1;
      MATCH_EVENT <= 8'h01 << i;
      @(posedge CLOCK);
      MATCH_EVENT <= 8'h00;
      @(posedge CLOCK);
      check("wake", {31'h0, WAKE}, 32'h1);
      check("irq", {31'h0, IRQ}, 32'h0);
      rd(4'(i / 4), 8'h10 << (i % 4));
      LOW_POWER <= 1'h0;
      acc(1'h1, 4'(i / 4), 8'h11 << (i % 4));
      take(16'h0010 + 16'(4 * i));
      rd(4'(i / 4), 8'h11 << (i % 4));
      acc(1'h1, 4'(i / 4), 8'h00);
      return_from_interrupt;
    end
    $display("test sources done");
    acc(1'h1, 4'h0, 8'h11);
    for (int k = 0; k < 16; k++)
    begin
      acc(1'h1, 4'h2, 8'h01);
      take(16'h0010);
    end
    acc(1'h1, 4'h2, 8'h01);
    repeat (8) @(posedge CLOCK);
    rd(4'h3, 32'h0010_1001);
    NRST <= 1'h0;
    @(posedge CLOCK);
    NRST <= 1'h1;
    @(posedge CLOCK);
    rd(4'h3, 32'h0000_0000);
    $display("test stack done");
    repeat (3) @(posedge CLOCK);
    conclude;
  end
endmodule
bind tmint_ctrl tmint_props chk (.*);
